// ==== src/sleep_pkg.sv ====
// Purpose: shared constants and types for the sleep and program-entry block
// Assumes: 125 MHz system clock, register bus with 32-bit data
// Notes:   offsets are byte addresses of aligned words
package sleep_pkg;
	// ****************************************
	// clock and timing
	// ****************************************
	localparam int unsigned CLK_PERIOD_NS   = 8;
	localparam int unsigned CLK_FREQ_KHZ    = 125_000;
	localparam int unsigned OSC_PERIOD_NS   = 8;        // one oscillator period
	localparam int unsigned OST_OSC_PERIODS = 1024;     // start-up delay in periods
	localparam int unsigned OST_TIME_NS     = OST_OSC_PERIODS * OSC_PERIOD_NS;
	localparam int unsigned OST_CYCLES      =
		(OST_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WDT_TIME_MS     = 18;       // nominal watchdog period
	localparam int unsigned WDT_CYCLES      = WDT_TIME_MS * CLK_FREQ_KHZ;
	localparam int unsigned WDT_W           = 22;
	localparam int unsigned OST_W           = 11;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [3:0] REG_STATUS = 4'h0;
	localparam logic [3:0] REG_CONFIG = 4'h4;
	localparam int unsigned STAT_PD_BIT   = 3;
	localparam int unsigned STAT_TO_BIT   = 4;
	localparam int unsigned STAT_SLP_BIT  = 0;
	localparam int unsigned STAT_PROG_BIT = 1;
	localparam int unsigned CFG_WDT_BIT   = 0;
	localparam int unsigned CFG_RC_BIT    = 1;
	localparam int unsigned CFG_CP_BIT    = 2;
	localparam logic [2:0] CONFIG_RESET   = 3'h0;
	// ****************************************
	// interrupt sources and core addresses
	// ****************************************
	localparam int unsigned IRQ_N     = 10;
	localparam int unsigned IRQ_EXT   = 0;
	localparam int unsigned IRQ_PORTCH = 1;
	localparam int unsigned IRQ_TMR16 = 2;
	// bits 0..7 may wake the core; 8..9 need the phase clocks
	localparam logic [IRQ_N-1:0] WAKE_CAPABLE = 10'h0ff;
	localparam logic [12:0] IRQ_VECTOR = 13'h0004;
	localparam logic [12:0] PC_START   = 13'h0000;
	// ****************************************
	// program/verify link
	// ****************************************
	localparam int unsigned CMD_W  = 6;
	localparam int unsigned WORD_W = 14;
	localparam logic [5:0] CMD_LOAD_CONFIG = 6'h00;
	localparam logic [5:0] CMD_LOAD_DATA   = 6'h02;
	localparam logic [5:0] CMD_READ_DATA   = 6'h04;
	localparam logic [5:0] CMD_INC_ADDR    = 6'h06;
	localparam logic [13:0] ID_BASE        = 14'h2000;
	localparam int unsigned ID_WORDS       = 4;

	typedef enum logic [1:0] {
		PS_RUN   = 2'b00,
		PS_SLEEP = 2'b01,
		PS_OST   = 2'b11,
		PS_WAKE  = 2'b10
	} power_state_t;

	typedef enum logic [1:0] {
		LS_CMD  = 2'b00,
		LS_LOAD = 2'b01,
		LS_READ = 2'b11
	} link_state_t;

	typedef struct packed {
		logic [7:0] level;   // driven level
		logic [7:0] oe_n;    // low while driving
	} io_state_t;
endpackage

// ==== src/sleep_ctrl.sv ====
// Purpose: sleep entry, wake-up, status flags, watchdog and program/verify entry
// Assumes: core pulses sleep_instr for one cycle; all pins synchronous to clock
// Notes:   registers reached over Avalon-MM; ID words only over the serial link
`default_nettype none
`timescale 1ns/1ns

module sleep_ctrl
	import sleep_pkg::*;
#(
	parameter int unsigned WDT_TIMEOUT = sleep_pkg::WDT_CYCLES
) (
	input  wire logic                        clock,
	input  wire logic                        sys_rst,
	// avalon-mm slave
	input  wire logic [3:0]                  avs_address,
	input  wire logic                        avs_read,
	input  wire logic                        avs_write,
	input  wire logic [31:0]                 avs_writedata,
	output logic [31:0]                      avs_readdata,
	output logic                             avs_waitrequest,
	// cpu core side
	input  wire logic                        sleep_instr,
	input  wire logic                        clear_watchdog_instr,
	input  wire logic [12:0]                 core_pc,
	input  wire logic                        global_irq_enable,
	input  wire logic [sleep_pkg::IRQ_N-1:0] irq_flags,
	input  wire logic [sleep_pkg::IRQ_N-1:0] irq_enables,
	input  wire logic                        tmr16_async,
	output logic [sleep_pkg::IRQ_N-1:0]      irq_flags_gated,
	output logic                             prefetch_req,
	output logic [12:0]                      prefetch_addr,
	output logic                             core_clock_en,
	output logic                             osc_drive_en,
	output logic                             device_reset,
	output logic                             resume_exec,
	output logic                             branch_vector,
	output logic [12:0]                      vector_addr,
	output logic                             sleeping,
	// port state from core and to pins
	input  wire sleep_pkg::io_state_t        port_core,
	output sleep_pkg::io_state_t             port_pins,
	// pins
	input  wire logic                        master_clear_pin_n,
	input  wire logic                        vpp_high,
	input  wire logic                        prog_clock_pin,
	input  wire logic                        prog_data_pin,
	output logic                             prog_data_out,
	output logic                             prog_data_oe_n,
	output logic                             prog_mode,
	// program memory port
	output logic [12:0]                      pm_addr,
	output logic [13:0]                      pm_wdata,
	output logic                             pm_we,
	input  wire logic [13:0]                 pm_rdata
);
	// ****************************************
	// declarations
	// ****************************************
	localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WDT_TIMEOUT - 1);
	localparam logic [OST_W-1:0] OST_LAST = OST_W'(OST_CYCLES - 1);

	power_state_t     pstate_ff, nxt_pstate;
	link_state_t      lstate_ff, nxt_lstate;
	logic             pd_ff, to_ff;
	logic [2:0]       cfg_ff;
	logic [WDT_W-1:0] wdt_ff;
	logic [OST_W-1:0] ost_ff;
	io_state_t        hold_ff;
	logic             ack_ff;
	logic [31:0]      rdata_ff;
	logic             pref_ff, resume_ff, branch_ff, wreset_ff;
	logic [12:0]      paddr_ff;
	logic             vpp_ff, pclk_ff;
	logic [13:0]      pc_ff;
	logic [13:0]      shift_ff;
	logic [3:0]       bits_ff;
	logic [13:0]      id_mem [ID_WORDS];

	// ****************************************
	// wake decode
	// ****************************************
	// a source wakes only with its own enable set; the global enable is
	// deliberately left out so a masked core can still be woken
	function automatic logic any_wake(input logic [IRQ_N-1:0] f,
	                                  input logic [IRQ_N-1:0] e,
	                                  input logic             t16);
		logic [IRQ_N-1:0] m;
		m = WAKE_CAPABLE;
		m[IRQ_TMR16] = t16;                        // only as async counter
		return |(f & e & m);
	endfunction

	wire wdt_on      = cfg_ff[CFG_WDT_BIT];
	wire rc_mode     = cfg_ff[CFG_RC_BIT];
	wire code_prot   = cfg_ff[CFG_CP_BIT];
	wire asleep      = (pstate_ff == PS_SLEEP);
	wire master_clear_pin_rst    = ~master_clear_pin_n & ~vpp_high;
	wire irq_pending = any_wake(irq_flags, irq_enables, tmr16_async);
	wire sleep_go    = sleep_instr & (pstate_ff == PS_RUN) & ~prog_mode;
	wire sleep_nop   = sleep_go & irq_pending;
	wire sleep_take  = sleep_go & ~irq_pending;
	wire wdt_expire  = wdt_on & (wdt_ff == WDT_LAST);
	wire wdt_clear   = clear_watchdog_instr | sleep_take;

	// ****************************************
	// power state machine
	// ****************************************
	// run, sleep, start-up wait, wake; master clear overrides every state
	// so a reset is never lost behind the start-up counter, and the
	// crystal wait is skipped in rc mode
	always_comb begin
		nxt_pstate = pstate_ff;
		unique case (pstate_ff)
			PS_RUN:   if (sleep_take) nxt_pstate = PS_SLEEP;
			PS_SLEEP: if (irq_pending | wdt_expire) begin
				nxt_pstate = rc_mode ? PS_WAKE : PS_OST;
			end
			PS_OST:   if (ost_ff == OST_LAST) nxt_pstate = PS_WAKE;
			PS_WAKE:  nxt_pstate = PS_RUN;
		endcase
		if (master_clear_pin_rst) nxt_pstate = PS_RUN;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) pstate_ff <= PS_RUN;
		else pstate_ff <= nxt_pstate;
	end

	// oscillator start-up counter
	always_ff @(posedge clock) begin
		if (sys_rst || pstate_ff != PS_OST) ost_ff <= '0;
		else ost_ff <= ost_ff + OST_W'(1);
	end

	// ****************************************
	// status flags
	// ****************************************
	// timeout clear wins over the set of the same cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pd_ff <= 1'b1;
			to_ff <= 1'b1;
		end else begin
			if (sleep_take) begin
				pd_ff <= 1'b0;
				to_ff <= 1'b1;
			end else if (clear_watchdog_instr) begin
				pd_ff <= 1'b1;
				to_ff <= 1'b1;
			end
			if (wdt_expire) to_ff <= 1'b0;
		end
	end

	// ****************************************
	// watchdog
	// ****************************************
	always_ff @(posedge clock) begin
		if (sys_rst || !wdt_on || wdt_clear || wdt_expire) wdt_ff <= '0;
		else wdt_ff <= wdt_ff + WDT_W'(1);                    // runs asleep too
	end

	// timeout while awake resets, while asleep wakes
	always_ff @(posedge clock) begin
		if (sys_rst) wreset_ff <= 1'b0;
		else wreset_ff <= wdt_expire & ~asleep & (pstate_ff == PS_RUN);
	end

	// ****************************************
	// prefetch and resume
	// ****************************************
	// prefetch pulse follows every sleep the core issues while running outside program mode, taken or not;
	// resume and vector pulses come one cycle after the wake state, and the
	// vector needs the waking source still pending at that point
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pref_ff   <= 1'b0;
			paddr_ff  <= '0;
			resume_ff <= 1'b0;
			branch_ff <= 1'b0;
		end else begin
			pref_ff <= sleep_go;
			if (sleep_go) paddr_ff <= core_pc + 13'h0001;
			resume_ff <= (pstate_ff == PS_WAKE) & ~master_clear_pin_rst;
			branch_ff <= (pstate_ff == PS_WAKE) & ~master_clear_pin_rst
				& global_irq_enable & irq_pending;
		end
	end

	// ****************************************
	// port hold
	// ****************************************
	// the copy follows the core while running and freezes on sleep entry,
	// so pins keep level and enable until clocks come back
	always_ff @(posedge clock) begin
		if (sys_rst) hold_ff <= '{level: 8'h00, oe_n: 8'hff};
		else if (pstate_ff == PS_RUN) hold_ff <= port_core;
	end

	// ****************************************
	// core-facing outputs
	// ****************************************
	wire clocks_on = (pstate_ff == PS_RUN) | (pstate_ff == PS_WAKE);
	assign core_clock_en   = clocks_on;
	assign osc_drive_en    = ~asleep;
	assign irq_flags_gated = clocks_on ? irq_flags
		: (irq_flags & WAKE_CAPABLE);
	assign port_pins       = clocks_on ? port_core : hold_ff;
	assign sleeping        = ~clocks_on;
	assign prefetch_req    = pref_ff;
	assign prefetch_addr   = paddr_ff;
	assign resume_exec     = resume_ff;
	assign branch_vector   = branch_ff;
	assign vector_addr     = IRQ_VECTOR;
	assign device_reset    = master_clear_pin_rst | wreset_ff;

	// ****************************************
	// program/verify link
	// ****************************************
	wire pclk_rise = prog_clock_pin & ~pclk_ff;
	wire entry     = vpp_high & ~vpp_ff & ~prog_clock_pin & ~prog_data_pin;
	wire last_cmd  = (bits_ff == 4'(CMD_W - 1));
	wire last_word = (bits_ff == 4'(WORD_W - 1));
	wire [5:0] cmd = {prog_data_pin, shift_ff[13:9]};
	wire in_id     = (pc_ff[13:2] == ID_BASE[13:2]);
	wire [1:0] id_ix = pc_ff[1:0];
	wire [13:0] rd_word = in_id ? id_mem[id_ix]
		: (code_prot ? 14'h0000 : pm_rdata);

	// entry needs the rise of the high voltage with clock and data low;
	// mode drops as soon as the high voltage goes away, which also parks
	// the link state machine through its reset below
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			vpp_ff    <= 1'b0;
			pclk_ff   <= 1'b0;
			prog_mode <= 1'b0;
		end else begin
			vpp_ff  <= vpp_high;
			pclk_ff <= prog_clock_pin;
			if (entry) prog_mode <= 1'b1;
			else if (!vpp_high) prog_mode <= 1'b0;
		end
	end

	// link phase moves only on a programming clock rise; unknown commands
	// stay in the command phase and are otherwise ignored
	always_comb begin
		nxt_lstate = lstate_ff;
		if (pclk_rise) begin
			unique case (lstate_ff)
				LS_CMD: if (last_cmd) begin
					if (cmd == CMD_LOAD_DATA) nxt_lstate = LS_LOAD;
					else if (cmd == CMD_LOAD_CONFIG) nxt_lstate = LS_LOAD;
					else if (cmd == CMD_READ_DATA) nxt_lstate = LS_READ;
				end
				LS_LOAD, LS_READ: if (last_word) nxt_lstate = LS_CMD;
				default: nxt_lstate = LS_CMD;
			endcase
		end
	end

	// shift, count and address
	always_ff @(posedge clock) begin
		if (sys_rst || !prog_mode) begin
			lstate_ff <= LS_CMD;
			shift_ff  <= '0;
			bits_ff   <= '0;
			pc_ff     <= {1'b0, PC_START};
		end else if (pclk_rise) begin
			lstate_ff <= nxt_lstate;
			bits_ff   <= (lstate_ff == LS_CMD && last_cmd) || last_word
				? 4'h0 : bits_ff + 4'h1;
			if (lstate_ff == LS_CMD && last_cmd) begin
				if (cmd == CMD_INC_ADDR) pc_ff <= pc_ff + 14'h0001;
				if (cmd == CMD_LOAD_CONFIG) pc_ff <= ID_BASE;
				shift_ff <= (cmd == CMD_READ_DATA) ? rd_word : '0;
			end else if (lstate_ff == LS_READ) begin
				shift_ff <= {1'b0, shift_ff[13:1]};
			end else begin
				shift_ff <= {prog_data_pin, shift_ff[13:1]};
			end
		end
	end

	// completed loads go to the ID words, or to program memory below ID_BASE
	wire load_done = prog_mode & pclk_rise & (lstate_ff == LS_LOAD) & last_word;
	wire [13:0] load_word = {prog_data_pin, shift_ff[13:1]};

	always_ff @(posedge clock) begin
		if (load_done && in_id) id_mem[id_ix] <= load_word;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pm_we    <= 1'b0;
			pm_wdata <= '0;
		end else begin
			pm_we <= load_done & ~in_id & ~pc_ff[13];
			if (load_done) pm_wdata <= load_word;
		end
	end

	assign pm_addr        = pc_ff[12:0];
	assign prog_data_out  = shift_ff[0];
	assign prog_data_oe_n = ~(prog_mode & (lstate_ff == LS_READ));

	// ****************************************
	// register slave
	// ****************************************
	wire req       = avs_read | avs_write;
	wire hit_stat  = (avs_address == REG_STATUS);
	wire hit_cfg   = (avs_address == REG_CONFIG);
	logic [31:0] stat_word;

	// status word built from the named bit positions; spare bits read zero
	always_comb begin
		stat_word                = 32'h0000_0000;
		stat_word[STAT_SLP_BIT]  = sleeping;
		stat_word[STAT_PROG_BIT] = prog_mode;
		stat_word[STAT_PD_BIT]   = pd_ff;
		stat_word[STAT_TO_BIT]   = to_ff;
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ack_ff   <= 1'b0;
			rdata_ff <= '0;
			cfg_ff   <= CONFIG_RESET;
		end else begin
			// the first cycle launches read data and the acknowledge; a write
			// lands only at the edge where waitrequest is low, so a held
			// request takes effect exactly once
			ack_ff <= req & ~ack_ff;
			if (req && !ack_ff) begin
				rdata_ff <= hit_stat ? stat_word
					: hit_cfg ? {29'h0000_0000, cfg_ff} : 32'h0000_0000;
			end
			if (avs_write && hit_cfg && ack_ff) cfg_ff <= avs_writedata[2:0];
		end
	end

	assign avs_waitrequest = req & ~ack_ff;
	assign avs_readdata    = rdata_ff;
endmodule // sleep_ctrl
`default_nettype wire

// ==== tb/sleep_ctrl_monitor.sv ====
// Purpose: port-level checks for the sleep controller
// Assumes: one clock domain, sys_rst synchronous active high
// Notes:   attached to every sleep_ctrl by the bind at the foot
`timescale 1ns/1ns
`default_nettype none
module sleep_ctrl_monitor
	import sleep_pkg::*;
(
	input wire logic			clock,
	input wire logic			sys_rst,
	input wire logic			sleep_instr,
	input wire logic [12:0]			core_pc,
	input wire logic			global_irq_enable,
	input wire logic [sleep_pkg::IRQ_N-1:0]	irq_flags,
	input wire logic [sleep_pkg::IRQ_N-1:0]	irq_enables,
	input wire logic [sleep_pkg::IRQ_N-1:0]	irq_flags_gated,
	input wire logic			prefetch_req,
	input wire logic [12:0]			prefetch_addr,
	input wire logic			core_clock_en,
	input wire logic			osc_drive_en,
	input wire logic			device_reset,
	input wire logic			resume_exec,
	input wire logic			branch_vector,
	input wire logic [12:0]			vector_addr,
	input wire logic			sleeping,
	input wire sleep_pkg::io_state_t	port_pins,
	input wire logic			master_clear_pin_n,
	input wire logic			vpp_high,
	input wire logic			prog_data_oe_n,
	input wire logic			prog_mode
);
	// enabled wake sources pending, timer left out as it needs async mode
	wire logic [IRQ_N-1:0] wake_pend;
	assign wake_pend = irq_flags & irq_enables & 10'h0fb;
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	// ****************************************
	// checks
	// ****************************************
	a_sleep_prefetch: assert property (
		sleep_instr && !sleeping && !prog_mode && !resume_exec
		|=> prefetch_req && prefetch_addr == $past(core_pc) + 13'h0001)
		else $error("no prefetch of next address after sleep");
	a_osc_off: assert property (!osc_drive_en |-> sleeping && !core_clock_en)
		else $error("oscillator off while running");
	a_ports_held: assert property (sleeping && $past(sleeping) |-> $stable(port_pins))
		else $error("port state moved while asleep");
	a_clk_irq_off: assert property (sleeping |-> irq_flags_gated[9:8] == 2'b00)
		else $error("clock-dependent interrupt seen while asleep");
	a_vector_fixed: assert property (branch_vector |-> resume_exec && vector_addr == 13'h0004)
		else $error("vector branch without resume or wrong address");
	a_vector_gie: assert property (
		resume_exec && !global_irq_enable && !$past(global_irq_enable) |-> !branch_vector)
		else $error("vector branch with global enable clear");
	a_master_clear_pin_reset: assert property (!master_clear_pin_n && !vpp_high |-> device_reset)
		else $error("master clear gave no reset");
	a_wake_resumes: assert property (
		$fell(sleeping) && !$past(sys_rst) && $past(master_clear_pin_n) |-> ##[1:2] resume_exec)
		else $error("wake without resume pulse");
	a_sleep_nop: assert property (
		sleep_instr && !sleeping && !prog_mode && wake_pend != 10'h000 |=> !sleeping[*2])
		else $error("sleep taken with enabled interrupt pending");
	a_link_drive: assert property (!prog_data_oe_n |-> prog_mode)
		else $error("data pin driven outside program mode");
endmodule // sleep_ctrl_monitor
bind sleep_ctrl sleep_ctrl_monitor sleep_ctrl_monitor_inst (.clock, .sys_rst, .sleep_instr,
	.core_pc, .global_irq_enable, .irq_flags, .irq_enables, .irq_flags_gated, .prefetch_req,
	.prefetch_addr, .core_clock_en, .osc_drive_en, .device_reset, .resume_exec,
	.branch_vector, .vector_addr, .sleeping, .port_pins, .master_clear_pin_n, .vpp_high,
	.prog_data_oe_n, .prog_mode);
`default_nettype wire

// ==== tb/prog_link_model.sv ====
// Purpose: behavioural programmer on the two-wire program/verify link
// Assumes: bits go least significant first, one per clock pulse
// Notes:   link clock stands low outside frames; the data line shows the device data while the device drives it
`timescale 1ns/1ns
`default_nettype none
module prog_link_model (
	input  wire logic	clock,
	input  wire logic	data_line,
	output logic		prog_clk,
	output logic		data_drv,
	output logic		vpp
);
	// clock and data start low so entry sees them low
	initial begin
		prog_clk = 1'b0;
		data_drv = 1'b0;
		vpp = 1'b0;
	end
	// raise the programming voltage with clock and data held low
	task automatic enter();
		repeat (4) @(posedge clock);
		vpp <= 1'b1;
		repeat (8) @(posedge clock);
	endtask
	// one pulse, data set before the rise and held past the fall
	task automatic put_bit(input logic b);
		data_drv <= b;
		repeat (4) @(posedge clock);
		prog_clk <= 1'b1;
		repeat (4) @(posedge clock);
		prog_clk <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	// six command bits, lowest first
	task automatic send_cmd(input logic [5:0] c);
		@(posedge clock);
		for (int i = 0; i < 6; i++) put_bit(c[i]);
	endtask
	// invert the driven bit and take a word; each bit is taken before the rise that moves it on
	task automatic read_word(output logic [13:0] wd);
		data_drv <= ~data_drv;
		for (int i = 0; i < 14; i++) begin
			repeat (4) @(posedge clock);
			wd[i] = data_line;
			prog_clk <= 1'b1;
			repeat (4) @(posedge clock);
			prog_clk <= 1'b0;
		end
		repeat (4) @(posedge clock);
	endtask
	// fourteen data bits, lowest first
	task automatic load_word(input logic [13:0] wd);
		for (int i = 0; i < 14; i++) put_bit(wd[i]);
	endtask
endmodule // prog_link_model
`default_nettype wire

// ==== tb/sleep_wakeup_and_serial_program_entry_bench.sv ====
// Purpose: self-checking bench for sleep entry, wake-up and program entry
// Assumes: watchdog shortened to 64 cycles; oscillator period equals clock
// Notes:   programmer side is prog_link_model
`timescale 1ns/1ns
`default_nettype none
module sleep_wakeup_and_serial_program_entry_bench;
	import sleep_pkg::*;
	logic		clock, sys_rst, avs_read, avs_write, avs_waitrequest;
	logic [3:0]	avs_address;
	logic [31:0]	avs_writedata, avs_readdata, q;
	logic		sleep_instr, clear_watchdog_instr, global_irq_enable, tmr16_async;
	logic [12:0]	core_pc, prefetch_addr, vector_addr, pm_addr;
	logic [IRQ_N-1:0]	irq_flags, irq_enables, irq_flags_gated;
	logic		prefetch_req, core_clock_en, osc_drive_en, device_reset, resume_exec;
	logic		branch_vector, sleeping, prog_mode, pm_we, master_clear_pin_n, vpp_high;
	logic		prog_clock_pin, prog_data_out, prog_data_oe_n, drv;
	wire logic	prog_data_pin;
	io_state_t	port_core, port_pins;
	logic [13:0]	pm_wdata, pm_rdata, w;
	int		checks = 0;
	int		num_errors = 0;
	int		n;
	// data wire: device while its enable is low, else the programmer
	assign prog_data_pin = !prog_data_oe_n ? prog_data_out : drv;
	sleep_ctrl #(.WDT_TIMEOUT(64)) sleep_ctrl_inst (.clock, .sys_rst, .avs_address, .avs_read,
		.avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest, .sleep_instr,
		.clear_watchdog_instr, .core_pc, .global_irq_enable, .irq_flags, .irq_enables,
		.tmr16_async, .irq_flags_gated, .prefetch_req, .prefetch_addr, .core_clock_en,
		.osc_drive_en, .device_reset, .resume_exec, .branch_vector, .vector_addr, .sleeping,
		.port_core, .port_pins, .master_clear_pin_n, .vpp_high, .prog_clock_pin,
		.prog_data_pin, .prog_data_out, .prog_data_oe_n, .prog_mode, .pm_addr, .pm_wdata,
		.pm_we, .pm_rdata);
	prog_link_model prog_link_model_inst (.clock, .data_line(prog_data_pin),
		.prog_clk(prog_clock_pin), .data_drv(drv), .vpp(vpp_high));
	// compare helpers, verdict and the bounded-wait failure exit
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic chkb(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task automatic close_out();
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic lost();
		chk(32'h0000_0000, 32'h0000_0001);
		close_out();
	endtask
	// one avalon access, held until waitrequest is seen low
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		int k = 0;
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= ~wr;
		avs_write <= wr;
		do begin
			@(posedge clock);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		if (k >= 50) lost();
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0000_0000);
		chk(q, e);
	endtask
	// one-cycle sleep (s=1) or clear-watchdog (s=0) instruction
	task automatic pulse(input logic s);
		@(posedge clock);
		{sleep_instr, clear_watchdog_instr} <= s ? 2'b10 : 2'b01;
		@(posedge clock);
		{sleep_instr, clear_watchdog_instr} <= 2'b00;
		repeat (3) @(posedge clock);
	endtask
	task automatic wait_res(input int lim);
		n = 0;
		while (resume_exec !== 1'b1 && n < lim) begin
			@(posedge clock);
			n++;
		end
		if (n >= lim) lost();
	endtask
	// scenarios
	task automatic t_reset();
		rd(4'h0, 32'h0000_0018);
		bus(1'b1, 4'h0, 32'h0000_0000);
		rd(4'h0, 32'h0000_0018);
		rd(4'h4, 32'h0000_0000);
		bus(1'b1, 4'h8, 32'h0000_0007);
		rd(4'h8, 32'h0000_0000);
	endtask
	task automatic t_xtal();
		global_irq_enable <= 1'b1;
		irq_enables <= 10'h301;
		pulse(1'b1);
		rd(4'h0, 32'h0000_0011);
		port_core <= 16'h3cf0;
		irq_flags <= 10'h300;
		repeat (20) @(posedge clock);
		chkb(sleeping, 1'b1);
		chk({16'h0000, port_pins}, 32'h0000_5a0f);
		irq_flags <= 10'h001;
		wait_res(1200);
		chkb(n >= 1024, 1'b1);
		chkb(branch_vector, 1'b1);
		irq_flags <= 10'h000;
		rd(4'h0, 32'h0000_0010);
	endtask
	task automatic t_rc();
		bus(1'b1, 4'h4, 32'h0000_0002);
		global_irq_enable <= 1'b0;
		irq_enables <= 10'h004;
		pulse(1'b1);
		irq_flags <= 10'h004;
		repeat (20) @(posedge clock);
		chkb(sleeping, 1'b1);
		tmr16_async <= 1'b1;
		wait_res(40);
		chkb(n < 8, 1'b1);
		chkb(branch_vector, 1'b0);
		irq_flags <= 10'h000;
		tmr16_async <= 1'b0;
	endtask
	task automatic t_nop();
		pulse(1'b0);
		irq_enables <= 10'h008;
		irq_flags <= 10'h008;
		pulse(1'b1);
		chkb(sleeping, 1'b0);
		rd(4'h0, 32'h0000_0018);
		irq_flags <= 10'h000;
	endtask
	task automatic t_wdt();
		bus(1'b1, 4'h4, 32'h0000_0003);
		repeat (40) @(posedge clock);
		pulse(1'b1);
		wait_res(200);
		chkb(n > 50, 1'b1);
		bus(1'b1, 4'h4, 32'h0000_0002);
		rd(4'h0, 32'h0000_0000);
	endtask
	task automatic t_master_clear_pin();
		pulse(1'b1);
		n = 0;
		master_clear_pin_n <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			@(posedge clock);
			master_clear_pin_n <= (i >= 2);
			if (resume_exec === 1'b1) n++;
		end
		chk(n, 32'h0000_0000);
		chkb(sleeping, 1'b0);
	endtask
	task automatic t_prog();
		pm_rdata <= 14'h2a5c;
		prog_link_model_inst.enter();
		chkb(prog_mode, 1'b1);
		prog_link_model_inst.send_cmd(CMD_READ_DATA);
		chk({19'h0, pm_addr}, 32'h0000_0000);
		prog_link_model_inst.read_word(w);
		chk({18'h0, w}, 32'h0000_2a5c);
		bus(1'b1, 4'h4, 32'h0000_0004);
		prog_link_model_inst.send_cmd(CMD_READ_DATA);
		prog_link_model_inst.read_word(w);
		chk({18'h0, w}, 32'h0000_0000);
		prog_link_model_inst.send_cmd(CMD_LOAD_CONFIG);
		prog_link_model_inst.load_word(14'h0005);
		prog_link_model_inst.send_cmd(CMD_READ_DATA);
		prog_link_model_inst.read_word(w);
		chk({18'h0, w}, 32'h0000_0005);
	endtask
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	// time-zero values, reset, then the scenarios
	initial begin
		{sys_rst, master_clear_pin_n} = 2'b11;
		{avs_read, avs_write, sleep_instr, clear_watchdog_instr} = 4'h0;
		{global_irq_enable, tmr16_async} = 2'b00;
		avs_address = 4'h0;
		avs_writedata = 32'h0000_0000;
		{irq_flags, irq_enables} = 20'h0_0000;
		core_pc = 13'h0123;
		pm_rdata = 14'h0000;
		port_core = 16'h5a0f;
		repeat (16) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_xtal();
		t_rc();
		t_nop();
		t_wdt();
		t_master_clear_pin();
		t_prog();
		close_out();
	end
endmodule // sleep_wakeup_and_serial_program_entry_bench
`default_nettype wire
